// *** sfr_pkg.sv ***
// shared constants and types for the security fault reset supervisor
package sfr_pkg;
  localparam int CLK_PERIOD_NS = 10;

  // detector alarm indices
  localparam int NUM_ALARMS  = 13;
  localparam int AL_ANA_HI   = 0;
  localparam int AL_ANA_LO   = 1;
  localparam int AL_DIG_HI   = 2;
  localparam int AL_DIG_LO   = 3;
  localparam int AL_PROG_HI  = 4;
  localparam int AL_PROG_LO  = 5;
  localparam int AL_DIG_GLT  = 6;
  localparam int AL_LIGHT    = 7;
  localparam int AL_TEMP_HI  = 8;
  localparam int AL_TEMP_LO  = 9;
  localparam int AL_FREQ_LO  = 10;
  localparam int AL_FREQ_HI  = 11;
  localparam int AL_SHIELD   = 12;

  // timing: least times, rounded up to whole cycles
  localparam int RST_FILT_NS  = 200;
  localparam int RST_FILT_CYC = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST_STIM_NS   = 500;
  localparam int ST_STIM_CYC  = (ST_STIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_NS  = 160;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // fault cause bit positions
  localparam int C_ENV      = 0;
  localparam int C_SELFTEST = 1;
  localparam int C_INSTR    = 2;
  localparam int C_PARAM    = 3;
  localparam int C_SHIELD   = 4;
  localparam int C_AREA     = 5;
  localparam int C_EXTRST   = 6;

  // address map
  localparam logic [15:0] ROM_END  = 16'h7FFF;
  localparam logic [15:0] LIB_BASE = 16'hC000;
  localparam logic [15:0] LIB_END  = 16'hDFFF;
  localparam logic [15:0] ID_BASE  = 16'hE000;
  localparam logic [15:0] ID_END   = 16'hEFFF;
  localparam logic [15:0] TST_BASE = 16'hF000;

  // checks on opcodes and firmware parameters
  localparam logic [7:0]  ILL_OPC_BASE = 8'hF0;
  localparam logic [15:0] FW_PARAM_MIN = 16'h0001;
  localparam logic [15:0] FW_PARAM_MAX = 16'h7FFF;

  // memory scrambling keys, arbitrary values
  localparam logic [15:0] SCR_ADDR_KEY = 16'h5A3C;
  localparam logic [7:0]  SCR_DATA_KEY = 8'hA5;

  typedef enum logic [1:0] {S_ST_ON, S_ST_OFF, S_RUN, S_FAULT} sfr_state_t;
endpackage

// *** sfr_alarm_if.sv ***
// alarm and external reset signals between pin sampling and supervisor
`timescale 1ns/1ns
interface sfr_alarm_if;
  logic [sfr_pkg::NUM_ALARMS-1:0] raw;
  logic                           ext_rst_n_raw;
  logic [sfr_pkg::NUM_ALARMS-1:0] sync;
  logic                           ext_rst_filt;
  modport snc (input raw, input ext_rst_n_raw, output sync, output ext_rst_filt);
  modport sup (output raw, output ext_rst_n_raw, input sync, input ext_rst_filt);
endinterface

// *** sfr_alarm_sync.sv ***
// alarm synchronisers and external reset glitch filter
`timescale 1ns/1ns
module sfr_alarm_sync (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // alarm carrier
  sfr_alarm_if.snc  alm
);
  typedef struct packed {
    logic [sfr_pkg::NUM_ALARMS-1:0] s1;
    logic [sfr_pkg::NUM_ALARMS-1:0] s2;
    logic                           e1;
    logic                           e2;
    logic                           eq;
    logic [7:0]                     cnt;
  } sfr_sync_state_t;

  sfr_sync_state_t r;
  sfr_sync_state_t n;

  always_comb begin
    n    = r;
    n.s1 = alm.raw;
    n.s2 = r.s1;
    n.e1 = ~alm.ext_rst_n_raw;
    n.e2 = r.e1;
    // pin level must hold steady for the whole window to be taken
    if (r.e2 != r.eq) begin
      if (r.cnt == 8'(sfr_pkg::RST_FILT_CYC - 1)) begin
        n.eq  = r.e2;
        n.cnt = 8'h00;
      end else begin
        n.cnt = r.cnt + 8'h01;
      end
    end else begin
      n.cnt = 8'h00;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign alm.sync         = r.s2;
  assign alm.ext_rst_filt = r.eq;
endmodule

// *** sfr_supervisor.sv ***
// security fault reset supervisor: alarms, self-test, access checks, mode lock
`timescale 1ns/1ns
module sfr_supervisor (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // detector alarms
  input  wire logic        i_ana_supply_hi,
  input  wire logic        i_ana_supply_lo,
  input  wire logic        i_dig_supply_hi,
  input  wire logic        i_dig_supply_lo,
  input  wire logic        i_prog_supply_hi,
  input  wire logic        i_prog_supply_lo,
  input  wire logic        i_dig_supply_glitch,
  input  wire logic        i_light,
  input  wire logic        i_temp_hi,
  input  wire logic        i_temp_lo,
  input  wire logic        i_clk_freq_lo,
  input  wire logic        i_clk_freq_hi,
  input  wire logic        i_shield_alarm,
  output logic             o_selftest_stim,
  // external reset pin
  input  wire logic        i_ext_rst_n,
  // core reset and status
  output logic             o_core_rst,
  output logic [7:0]       o_fault_cause,
  output logic             o_selftest_ok,
  // instruction monitor
  input  wire logic        i_instr_valid,
  input  wire logic [7:0]  i_instr_opcode,
  // firmware parameter check
  input  wire logic        i_fw_param_valid,
  input  wire logic [15:0] i_fw_param,
  // processor bus
  input  wire logic        i_bus_valid,
  input  wire logic        i_bus_write,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_wdata,
  output logic             o_bus_grant,
  output logic             o_id_write_refused,
  output logic [7:0]       o_bus_rdata,
  // scrambled memory side
  output logic             o_mem_we,
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  // access mode
  input  wire logic        i_mode_set_valid,
  input  wire logic        i_mode_set_priv,
  output logic             o_priv_mode,
  // life-cycle mode
  input  wire logic        i_nv_test_lock,
  input  wire logic        i_test_entry_req,
  input  wire logic        i_final_test_done,
  output logic             o_test_mode,
  output logic             o_nv_lock_prog
);
  typedef struct packed {
    sfr_pkg::sfr_state_t st;
    logic [7:0]          cnt;
    logic [7:0]          cause;
    logic                priv;
    logic                test_mode;
    logic                lock;
    logic                lock_prog;
    logic                st_ok;
    logic                mem_we;
    logic [15:0]         mem_addr;
    logic [7:0]          mem_wdata;
    logic [7:0]          raddr_lo;
    logic [7:0]          rdata;
  } sfr_sup_state_t;

  sfr_sup_state_t r;
  sfr_sup_state_t n;

  sfr_alarm_if alm ();

  logic       run;
  logic       env_alarm;
  logic       in_rom;
  logic       in_lib;
  logic       in_id;
  logic       in_tst;
  logic       area_bad;
  logic       id_refuse;
  logic [7:0] cause_now;

  assign alm.raw = {i_shield_alarm, i_clk_freq_hi, i_clk_freq_lo, i_temp_lo, i_temp_hi,
                    i_light, i_dig_supply_glitch, i_prog_supply_lo, i_prog_supply_hi,
                    i_dig_supply_lo, i_dig_supply_hi, i_ana_supply_lo,
                    i_ana_supply_hi};
  assign alm.ext_rst_n_raw = i_ext_rst_n;

  sfr_alarm_sync u_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .alm       (alm)
  );

  assign run       = (r.st == sfr_pkg::S_RUN);
  // the clock rate alarms join the supply, glitch, light and temperature alarms here
  assign env_alarm = |alm.sync[sfr_pkg::AL_FREQ_HI:sfr_pkg::AL_ANA_HI];

  // area decode
  assign in_rom = (i_bus_addr <= sfr_pkg::ROM_END);
  assign in_lib = (i_bus_addr >= sfr_pkg::LIB_BASE) && (i_bus_addr <= sfr_pkg::LIB_END);
  assign in_id  = (i_bus_addr >= sfr_pkg::ID_BASE) && (i_bus_addr <= sfr_pkg::ID_END);
  assign in_tst = (i_bus_addr >= sfr_pkg::TST_BASE);

  assign area_bad  = i_bus_valid & ((in_lib & ~r.priv) | (in_tst & ~r.test_mode)
                                    | (in_rom & i_bus_write));
  // an identity write is only refused, not treated as an attack
  assign id_refuse = i_bus_valid & i_bus_write & in_id & ~r.test_mode;

  always_comb begin
    cause_now = 8'h00;
    if (r.st == sfr_pkg::S_RUN || r.st == sfr_pkg::S_FAULT) begin
      cause_now[sfr_pkg::C_ENV]    = env_alarm;
      cause_now[sfr_pkg::C_SHIELD] = alm.sync[sfr_pkg::AL_SHIELD];
      cause_now[sfr_pkg::C_EXTRST] = alm.ext_rst_filt;
    end
    if (run) begin
      cause_now[sfr_pkg::C_INSTR] = i_instr_valid
                                    & (i_instr_opcode >= sfr_pkg::ILL_OPC_BASE);
      cause_now[sfr_pkg::C_PARAM] = i_fw_param_valid
                                    & ((i_fw_param < sfr_pkg::FW_PARAM_MIN)
                                       | (i_fw_param > sfr_pkg::FW_PARAM_MAX));
      cause_now[sfr_pkg::C_AREA]  = area_bad;
    end
  end

  always_comb begin
    n           = r;
    n.lock_prog = 1'b0;
    n.mem_we    = 1'b0;
    n.rdata     = i_mem_rdata ^ sfr_pkg::SCR_DATA_KEY ^ r.raddr_lo;
    if (o_bus_grant) begin
      n.mem_we    = i_bus_write;
      n.mem_addr  = i_bus_addr ^ sfr_pkg::SCR_ADDR_KEY;
      n.mem_wdata = i_bus_wdata ^ sfr_pkg::SCR_DATA_KEY ^ i_bus_addr[7:0];
      n.raddr_lo  = i_bus_addr[7:0];
    end
    // lock reloads from the nonvolatile bit while held in reset; it can only rise until i_sys_rst clears it
    if (o_core_rst) begin
      n.lock = r.lock | i_nv_test_lock;
    end
    unique case (r.st)
      sfr_pkg::S_ST_ON: begin
        if (r.cnt == 8'(sfr_pkg::ST_STIM_CYC - 1)) begin
          n.cnt = 8'h00;
          if (&alm.sync) begin
            n.st = sfr_pkg::S_ST_OFF;
          end else begin
            n.st    = sfr_pkg::S_FAULT;
            n.cause = 8'h01 << sfr_pkg::C_SELFTEST;
          end
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
      sfr_pkg::S_ST_OFF: begin
        if (r.cnt == 8'(sfr_pkg::ST_STIM_CYC - 1)) begin
          n.cnt = 8'h00;
          if (~|alm.sync) begin
            n.st    = sfr_pkg::S_RUN;
            n.st_ok = 1'b1;
          end else begin
            n.st    = sfr_pkg::S_FAULT;
            n.cause = 8'h01 << sfr_pkg::C_SELFTEST;
          end
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
      sfr_pkg::S_RUN: begin
        if (|cause_now) begin
          n.st        = sfr_pkg::S_FAULT;
          n.cnt       = 8'h00;
          n.cause     = cause_now;
          n.priv      = 1'b0;
          n.test_mode = 1'b0;
        end else begin
          if (i_mode_set_valid) begin
            n.priv = i_mode_set_priv;
          end
          if (i_test_entry_req & ~r.lock) begin
            n.test_mode = 1'b1;
          end
          if (r.test_mode & i_final_test_done) begin
            n.test_mode = 1'b0;
            n.lock      = 1'b1;
            n.lock_prog = 1'b1;
          end
        end
      end
      sfr_pkg::S_FAULT: begin
        n.priv      = 1'b0;
        n.test_mode = 1'b0;
        n.cause     = r.cause | cause_now;
        // release only after the environment, shield and external reset causes have stayed clear for the hold time
        if (|cause_now) begin
          n.cnt = 8'h00;
        end else if (r.cnt == 8'(sfr_pkg::RST_HOLD_CYC - 1)) begin
          n.cnt = 8'h00;
          n.st  = r.cause[sfr_pkg::C_SELFTEST] ? sfr_pkg::S_ST_ON : sfr_pkg::S_RUN;
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // reset asserts in the same cycle as its cause
  assign o_core_rst         = ~run | (|cause_now);
  assign o_bus_grant        = i_bus_valid & run & ~(|cause_now) & ~id_refuse;
  assign o_id_write_refused = run & id_refuse;
  assign o_selftest_stim    = (r.st == sfr_pkg::S_ST_ON);
  assign o_fault_cause      = r.cause;
  assign o_selftest_ok      = r.st_ok;
  assign o_bus_rdata        = r.rdata;
  assign o_mem_we           = r.mem_we;
  assign o_mem_addr         = r.mem_addr;
  assign o_mem_wdata        = r.mem_wdata;
  assign o_priv_mode        = r.priv;
  assign o_test_mode        = r.test_mode;
  assign o_nv_lock_prog     = r.lock_prog;
endmodule

// *** sfr_asserts.sv ***
// port assertions for the security fault reset supervisor
`timescale 1ns/1ns
module sfr_asserts (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  // watched inputs
  input wire logic        i_clk_freq_lo,
  input wire logic        i_shield_alarm,
  input wire logic        i_instr_valid,
  input wire logic [7:0]  i_instr_opcode,
  input wire logic        i_fw_param_valid,
  input wire logic [15:0] i_fw_param,
  input wire logic        i_bus_valid,
  input wire logic        i_bus_write,
  input wire logic [15:0] i_bus_addr,
  input wire logic        i_nv_test_lock,
  // watched outputs
  input wire logic        o_core_rst,
  input wire logic        o_selftest_stim,
  input wire logic        o_bus_grant,
  input wire logic        o_id_write_refused,
  input wire logic        o_mem_we,
  input wire logic        o_priv_mode,
  input wire logic        o_test_mode,
  input wire logic        o_nv_lock_prog
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  property p_instr; i_instr_valid && i_instr_opcode >= 8'hF0 |-> o_core_rst; endproperty
  a_instr: assert property (p_instr) else $error("illegal opcode left core running");
  property p_param;
    i_fw_param_valid && (i_fw_param == 16'h0000 || i_fw_param[15]) |-> o_core_rst;
  endproperty
  a_param: assert property (p_param) else $error("bad parameter left core running");
  property p_shield; i_shield_alarm [*3] |-> o_core_rst; endproperty
  a_shield: assert property (p_shield) else $error("shield alarm missed");
  property p_freq; i_clk_freq_lo [*3] |-> o_core_rst; endproperty
  a_freq: assert property (p_freq) else $error("low clock alarm missed");
  property p_rom; i_bus_valid && i_bus_write && !i_bus_addr[15] |-> o_core_rst; endproperty
  a_rom: assert property (p_rom) else $error("rom write not treated as attack");
  property p_grant; o_bus_grant |-> i_bus_valid && !o_core_rst; endproperty
  a_grant: assert property (p_grant) else $error("grant during reset");
  property p_area;
    o_bus_grant |-> (i_bus_addr[15:13] != 3'b110 || o_priv_mode)
      && (i_bus_addr[15:12] != 4'hF || o_test_mode);
  endproperty
  a_area: assert property (p_area) else $error("forbidden region granted");
  property p_id;
    i_bus_valid && i_bus_write && i_bus_addr[15:12] == 4'hE && !o_test_mode && !o_core_rst
      |-> o_id_write_refused ##1 !o_mem_we;
  endproperty
  a_id: assert property (p_id) else $error("identity write not refused");
  property p_lock; $past(i_nv_test_lock) |-> !$rose(o_test_mode); endproperty
  a_lock: assert property (p_lock) else $error("test mode entered while locked");
  property p_prog; $rose(o_nv_lock_prog) |-> $fell(o_test_mode) ##1 !o_nv_lock_prog; endproperty
  a_prog: assert property (p_prog) else $error("lock programming pulse wrong");
  property p_hold; $rose(o_core_rst) |-> o_core_rst [*8]; endproperty
  a_hold: assert property (p_hold) else $error("core reset released too soon");
  property p_stim; o_selftest_stim |-> o_core_rst; endproperty
  a_stim: assert property (p_stim) else $error("core running during self-test");
endmodule

// *** sfr_env_model.sv ***
// detector bank, scrambled memory array and nonvolatile lock bit
`timescale 1ns/1ns
module sfr_env_model (
  // clock
  input  wire logic        i_clock,
  // detectors
  input  wire logic        i_stim,
  input  wire logic [12:0] i_force,
  input  wire logic [12:0] i_dead,
  output logic      [12:0] o_alarm,
  // memory and lock bit
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_prog,
  output logic      [7:0]  o_rdata,
  output logic             o_lock
);
  logic [7:0] mem [0:65535];
  initial o_lock = 1'b0;
  // dead detectors ignore the stimulus, so self-test can be failed on command
  assign o_alarm = (i_stim ? ~i_dead : 13'h0000) | i_force;
  assign o_rdata = mem[i_addr];
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_prog) begin
      o_lock <= 1'b1;
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the security fault reset supervisor
`timescale 1ns/1ns
module testbench;
  logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_ext_rst_n = 1'b1, i_instr_valid = 1'b0;
  logic        i_fw_param_valid = 1'b0, i_bus_valid = 1'b0, i_bus_write = 1'b0;
  logic [7:0]  i_instr_opcode = 8'h00, i_bus_wdata = 8'h00;
  logic [15:0] i_fw_param = 16'h0000, i_bus_addr = 16'h0000;
  logic [3:0]  ctl = 4'h0;
  logic [12:0] force_al = 13'h0000, dead = 13'h0000;
  wire  [12:0] alarm;
  wire         i_ana_supply_hi, i_ana_supply_lo, i_dig_supply_hi, i_dig_supply_lo;
  wire         i_prog_supply_hi, i_prog_supply_lo, i_dig_supply_glitch, i_light;
  wire         i_temp_hi, i_temp_lo, i_clk_freq_lo, i_clk_freq_hi, i_shield_alarm;
  wire         i_mode_set_valid, i_mode_set_priv, i_test_entry_req, i_final_test_done;
  wire         i_nv_test_lock, o_selftest_stim, o_core_rst, o_selftest_ok, o_bus_grant;
  wire         o_id_write_refused, o_mem_we, o_priv_mode, o_test_mode, o_nv_lock_prog;
  wire  [7:0]  i_mem_rdata, o_fault_cause, o_bus_rdata, o_mem_wdata;
  wire  [15:0] o_mem_addr;
  int          errors = 0, tests_run = 0;
  logic [31:0] seed = 32'h80F4C914;
  assign {i_shield_alarm, i_clk_freq_hi, i_clk_freq_lo, i_temp_lo, i_temp_hi, i_light,
          i_dig_supply_glitch, i_prog_supply_lo, i_prog_supply_hi, i_dig_supply_lo,
          i_dig_supply_hi, i_ana_supply_lo, i_ana_supply_hi} = alarm;
  assign {i_final_test_done, i_test_entry_req, i_mode_set_priv, i_mode_set_valid} = ctl;
  always #5 i_clock = ~i_clock;
  sfr_supervisor sfr_supervisor_inst (.*);
  sfr_env_model sfr_env_model_inst (.i_clock(i_clock), .i_stim(o_selftest_stim),
    .i_force(force_al), .i_dead(dead), .o_alarm(alarm), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_prog(o_nv_lock_prog), .o_rdata(i_mem_rdata),
    .o_lock(i_nv_test_lock));
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [7:0] scr(input logic [15:0] a, input logic [7:0] d);
    return d ^ sfr_pkg::SCR_DATA_KEY ^ a[7:0];
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic sys_reset();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    tick(12);
    i_sys_rst <= 1'b0;
  endtask
  // bounded wait; n counts cycles the core stays held
  task automatic wait_run(output int n);
    for (n = 0; o_core_rst !== 1'b0 && n < 400; n++) @(negedge i_clock);
    check("released", n < 400, 1'b1);
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge i_clock);
    ctl <= v;
    @(posedge i_clock);
    ctl <= 4'h0;
    @(negedge i_clock);
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input logic g);
    @(posedge i_clock);
    {i_bus_valid, i_bus_write, i_bus_addr, i_bus_wdata} <= {1'b1, w, a, d};
    @(negedge i_clock);
    check("grant", o_bus_grant, g);
    check("id_refused", o_id_write_refused, !g && w && a[15:12] == 4'hE);
    @(posedge i_clock);
    i_bus_valid <= 1'b0;
    @(negedge i_clock);
    check("mem_we", o_mem_we, g & w);
    if (g) check("mem_addr", o_mem_addr, a ^ sfr_pkg::SCR_ADDR_KEY);
    if (g & w) check("mem_wdata", o_mem_wdata, scr(a, d));
  endtask
  initial begin
    #200000;
    errors++;
    conclude();
  end
  initial begin
    int n, k, s;
    logic [15:0] a, r;
    logic [7:0] d;
    sys_reset();
    @(negedge i_clock);
    check("stim", {o_selftest_stim, o_core_rst}, 2'b11);
    wait_run(n);
    check("modes", {o_selftest_ok, o_test_mode, o_priv_mode}, 3'b100);
    // a short low pulse on the pin must be swallowed, a long one obeyed
    @(posedge i_clock);
    i_ext_rst_n <= 1'b0;
    tick(10);
    i_ext_rst_n <= 1'b1;
    tick(30);
    @(negedge i_clock);
    check("glitch", o_core_rst, 1'b0);
    @(posedge i_clock);
    i_ext_rst_n <= 1'b0;
    tick(40);
    i_ext_rst_n <= 1'b1;
    @(negedge i_clock);
    check("ext_rst", {o_core_rst, o_fault_cause[sfr_pkg::C_EXTRST]}, 2'b11);
    wait_run(n);
    repeat (4) begin
      a = 16'h8000 | (rnd() & 16'h3FFF);
      d = 8'(rnd());
      bus(1'b1, a, d, 1'b1);
      bus(1'b0, a, 8'h00, 1'b1);
      tick(2);
      @(negedge i_clock);
      check("rdata", o_bus_rdata, d);
    end
    pulse(4'h3);
    check("priv", o_priv_mode, 1'b1);
    bus(1'b0, 16'hDFFF, 8'h00, 1'b1);
    // back to user mode: o_priv_mode must read low again
    pulse(4'h1);
    check("user", o_priv_mode, 1'b0);
    pulse(4'h4);
    check("test_mode", o_test_mode, 1'b1);
    bus(1'b1, 16'hE000, 8'h5A, 1'b1);
    bus(1'b0, 16'hFFFF, 8'h00, 1'b1);
    pulse(4'h8);
    check("lock_prog", {o_test_mode, o_nv_lock_prog}, 2'b01);
    pulse(4'h4);
    check("relock", o_test_mode, 1'b0);
    bus(1'b1, 16'hEFFF, 8'hA5, 1'b0);
    check("no_reset", o_core_rst, 1'b0);
    // every detector, then opcode, parameter and area faults
    for (k = 0; k < 19; k++) begin
      r = rnd();
      @(posedge i_clock);
      force_al <= (k < 13) ? 13'h0001 << k : 13'h0000;
      {i_instr_valid, i_instr_opcode} <= {k == 13, 8'hF0 | r[7:0]};
      i_fw_param_valid <= (k == 14 || k == 15);
      i_fw_param <= (k == 14) ? 16'h0000 : 16'h8000 | r;
      {i_bus_valid, i_bus_write} <= {k > 15, k == 16};
      i_bus_addr <= (k == 16) ? r & 16'h7FFF : (k == 17) ? 16'hC000 | r[12:0] : 16'hF000 | r;
      tick(3);
      {force_al, i_instr_valid, i_fw_param_valid, i_bus_valid} <= '0;
      @(negedge i_clock);
      s = (k == 12) ? sfr_pkg::C_SHIELD : (k < 13) ? sfr_pkg::C_ENV : (k == 13) ?
          sfr_pkg::C_INSTR : (k < 16) ? sfr_pkg::C_PARAM : sfr_pkg::C_AREA;
      check("fault", {o_core_rst, o_fault_cause[s]}, 2'b11);
      wait_run(n);
      // wait starts two cycles into the fault, or at its entry for alarms, which stay two sync cycles after clearing
      s = (k < 13) ? sfr_pkg::RST_HOLD_CYC + 2 : sfr_pkg::RST_HOLD_CYC - 2;
      check("hold", 16'(n), 16'(s));
    end
    check("priv_clear", o_priv_mode, 1'b0);
    sys_reset();
    wait_run(n);
    pulse(4'h4);
    check("lock_kept", o_test_mode, 1'b0);
    @(posedge i_clock);
    dead <= 13'h0001 << (rnd() % 13);
    sys_reset();
    tick(120);
    @(negedge i_clock);
    s = sfr_pkg::C_SELFTEST;
    check("st_fail", {o_core_rst, o_selftest_ok, o_fault_cause[s]}, 3'b101);
    @(posedge i_clock);
    dead <= 13'h0000;
    wait_run(n);
    check("st_pass", o_selftest_ok, 1'b1);
    conclude();
  end
endmodule
bind sfr_supervisor sfr_asserts sfr_asserts_inst (.*);
